/* File: hw/pts_pkg.sv */
// Shared constants and types for the pressure/temperature sample buffer
package pts_pkg;

  // ==========================================================================
  // Sample and buffer geometry
  localparam int PRESS_W          = 24;
  localparam int TEMP_W           = 16;
  localparam int ENTRY_W          = 40;
  localparam int FIFO_DEPTH       = 128;
  localparam int PRESS_LSB_PER_HPA = 4096;
  localparam int TEMP_LSB_PER_DEGC = 100;

  // ==========================================================================
  // Register byte addresses
  localparam logic [6:0] A_THR_CFG   = 7'h0b;
  localparam logic [6:0] A_CTRL_TWO  = 7'h11;
  localparam logic [6:0] A_ROUTE     = 7'h12;
  localparam logic [6:0] A_BCTL      = 7'h13;
  localparam logic [6:0] A_WTM       = 7'h14;
  localparam logic [6:0] A_SRC       = 7'h24;
  localparam logic [6:0] A_LEVEL     = 7'h25;
  localparam logic [6:0] A_FLAGS     = 7'h26;
  localparam logic [6:0] A_P0        = 7'h28;
  localparam logic [6:0] A_P1        = 7'h29;
  localparam logic [6:0] A_P2        = 7'h2a;
  localparam logic [6:0] A_T0        = 7'h2b;
  localparam logic [6:0] A_T1        = 7'h2c;
  localparam logic [6:0] A_BP0       = 7'h78;
  localparam logic [6:0] A_BP1       = 7'h79;
  localparam logic [6:0] A_BP2       = 7'h7a;
  localparam logic [6:0] A_BT0       = 7'h7b;
  localparam logic [6:0] A_BT1       = 7'h7c;

  // ==========================================================================
  // Field positions and reset values
  localparam int AUTOINC_BIT       = 4;
  localparam int ROUTE_DRDY_BIT    = 2;
  localparam int ROUTE_OVR_BIT     = 3;
  localparam int ROUTE_WTM_BIT     = 4;
  localparam int ROUTE_FULL_BIT    = 5;
  localparam int BCTL_MODE_LSB     = 0;
  localparam int BCTL_TRIG_BIT     = 2;
  localparam int BCTL_STOP_BIT     = 3;
  localparam int SRC_IA_BIT        = 2;
  localparam int FLAG_WTM_BIT      = 7;
  localparam int FLAG_OVR_BIT      = 6;
  localparam int FLAG_FULL_BIT     = 5;
  localparam logic [7:0] CTRL_TWO_RST = 8'h10;
  localparam logic [7:0] REG_RST      = 8'h00;

  // ==========================================================================
  // Mode codes {trigger_mode_bit, mode[1:0]}
  localparam logic [2:0] MODE_BYPASS      = 3'h0;
  localparam logic [2:0] MODE_FIFO        = 3'h1;
  localparam logic [2:0] MODE_STREAM      = 3'h3;
  localparam logic [2:0] MODE_BYPASS_ALT  = 3'h4;
  localparam logic [2:0] MODE_BYP2FIFO    = 3'h5;
  localparam logic [2:0] MODE_BYP2STREAM  = 3'h6;
  localparam logic [2:0] MODE_STREAM2FIFO = 3'h7;

  typedef enum logic [1:0] {
    PTS_BHV_BYPASS,
    PTS_BHV_STOP,
    PTS_BHV_STREAM
  } pts_behave_t;

  typedef struct packed {
    logic [7:0]  thr_cfg;
    logic [7:0]  ctrl_two;
    logic [7:0]  route;
    logic [7:0]  bctl;
    logic [6:0]  wtm;
    logic [23:0] press;
    logic [15:0] temp;
    logic        drdy;
    logic        ovr;
    logic        trig;
    logic        ia_prev;
    logic [6:0]  ptr;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        irq;
  } pts_state_t;

endpackage

/* File: hw/pts_sample_fifo.sv */
// Sample FIFO with registered read data, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module pts_sample_fifo
#(
  parameter int WIDTH = 40,
  parameter int DEPTH = 128,
  localparam int AW   = $clog2(DEPTH),
  localparam int CW   = $clog2(DEPTH + 1)
)
(
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CW-1:0]         level
);

  typedef struct packed {
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [WIDTH-1:0] rd_data;
  } pts_fifo_state_t;

  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  pts_fifo_state_t  st_reg;
  pts_fifo_state_t  st_next;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
    inc_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // ==========================================================================
  // Next state
  always_comb
  begin
    // A full FIFO still takes data when the same cycle drains one entry
    in_ready  = (st_reg.count != FULL_CNT) | out_ready;
    out_valid = (st_reg.count != '0);
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    st_next   = st_reg;
    if (flush)
    begin
      st_next.wr_ptr = '0;
      st_next.rd_ptr = '0;
      st_next.count  = '0;
    end
    else
    begin
      if (push)
        st_next.wr_ptr = inc_ptr(st_reg.wr_ptr);
      if (pop)
        st_next.rd_ptr = inc_ptr(st_reg.rd_ptr);
      st_next.count = st_reg.count + CW'(push) - CW'(pop);
    end
    // Forward a write that lands in the slot about to be presented
    if (!flush && push && (st_reg.wr_ptr == st_next.rd_ptr))
      st_next.rd_data = in_data;
    else
      st_next.rd_data = mem[st_next.rd_ptr];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st_reg <= '0;
    else
      st_reg <= st_next;
    if (push && !flush && !srst)
      mem[st_reg.wr_ptr] <= in_data;
  end

  assign out_data = st_reg.rd_data;
  assign level    = st_reg.count;

endmodule

`default_nettype wire

/* File: hw/pts_buffer.sv */
// Register file, mode control and output logic of the sample buffer
//
// Function
// - Pressure is a signed 24-bit value in three byte registers.
// - Pressure codes scale at 4096 counts per hectopascal, direct or buffered.
// - Temperature is a signed 16-bit value in two bytes, 100 counts per degree.
// - Buffer holds 128 entries of 40 bits, pressure plus matching temperature.
// - Buffer is active for codes 001, 011 and 111, and for 101 and 110 once triggered; trigger bit plus mode pick behaviour.
// - Threshold flag is set while unread count is at or above threshold.
// - A zero threshold keeps the threshold flag cleared.
// - Overwrite flag reads one once an unread entry was overwritten.
// - Unread count reads zero when empty and 128 when full.
// - Codes 000 and 100 keep the buffer empty; only the latest sample is held.
// - Selecting bypass empties the buffer and clears the count.
// - Code 001 stores samples until the buffer is full.
// - Stop-at-threshold limits the buffer depth to a nonzero threshold; a zero threshold keeps full depth.
// - Code 011 stores continuously; first new sample after emptying reads first.
// - In continuous behaviour the count equals new samples available.
// - Code 101 is bypass until interrupt-active rises, then stop-when-full.
// - Code 110 is bypass until interrupt-active rises, then continuous.
// - Code 111 is continuous until interrupt-active rises, then stop-when-full.
// - Buffered bytes sit at 78h..7Ch; burst reads wrap 7Ch back to 78h.
// - Threshold, overwrite and full status route to the interrupt pin under enables.
// - Data-ready asserts whenever a new sample set arrives.
// - With auto-increment set, the default, the address advances per byte.
`timescale 1ns/1ps
`default_nettype none

module pts_buffer
#(
  parameter int DEPTH = pts_pkg::FIFO_DEPTH,
  localparam int CW   = $clog2(DEPTH + 1)
)
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        sample_valid,
  input  wire logic [23:0] sample_press,
  input  wire logic [15:0] sample_temp,
  input  wire logic        interrupt_active,
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_addr_load,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd_en,
  output logic [7:0]       reg_rdata,
  output logic             reg_rdata_valid,
  output logic             irq_output_pin,
  output logic             data_ready
);

  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  pts_pkg::pts_state_t  st_reg;
  pts_pkg::pts_state_t  st_next;
  pts_pkg::pts_behave_t bhv;
  logic [2:0]           code;
  logic [6:0]           acc_addr;
  logic                 rd;
  logic                 wr;
  logic [CW-1:0]        lim;
  logic                 full;
  logic                 host_pop;
  logic                 overwrite;
  logic                 fifo_in_valid;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 flush;
  logic [39:0]          fifo_data;
  logic [CW-1:0]        fifo_level;
  logic                 wtm_flag;
  logic                 full_flag;
  logic                 ia_rise;
  logic [7:0]           rd_mux;

  // ==========================================================================
  // Decoding helpers
  function automatic pts_pkg::pts_behave_t behave_of(input logic [2:0] c, input logic trig);
    unique case (c)
      pts_pkg::MODE_FIFO:        behave_of = pts_pkg::PTS_BHV_STOP;
      pts_pkg::MODE_STREAM:      behave_of = pts_pkg::PTS_BHV_STREAM;
      pts_pkg::MODE_BYP2FIFO:
        behave_of = trig ? pts_pkg::PTS_BHV_STOP : pts_pkg::PTS_BHV_BYPASS;
      pts_pkg::MODE_BYP2STREAM:
        behave_of = trig ? pts_pkg::PTS_BHV_STREAM : pts_pkg::PTS_BHV_BYPASS;
      pts_pkg::MODE_STREAM2FIFO:
        behave_of = trig ? pts_pkg::PTS_BHV_STOP : pts_pkg::PTS_BHV_STREAM;
      // 000, 100 and the undefined 010 all behave as bypass
      default:                   behave_of = pts_pkg::PTS_BHV_BYPASS;
    endcase
  endfunction

  function automatic logic is_trig_code(input logic [7:0] ctl);
    is_trig_code = ctl[pts_pkg::BCTL_TRIG_BIT]
                 && (ctl[pts_pkg::BCTL_MODE_LSB +: 2] != 2'h0);
  endfunction

  function automatic logic [6:0] advance(input logic [6:0] a);
    advance = (a == pts_pkg::A_BT1) ? pts_pkg::A_BP0 : a + 7'h01;
  endfunction

  // ==========================================================================
  // Buffer storage
  pts_sample_fifo
  #(
    .WIDTH (pts_pkg::ENTRY_W),
    .DEPTH (DEPTH)
  )
  u_fifo
  (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .flush     (flush),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({sample_temp, sample_press}),
    .out_valid (fifo_out_valid),
    .out_ready (host_pop | overwrite),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  // ==========================================================================
  // Control decode
  always_comb
  begin
    code     = {st_reg.bctl[pts_pkg::BCTL_TRIG_BIT],
                st_reg.bctl[pts_pkg::BCTL_MODE_LSB +: 2]};
    bhv      = behave_of(code, st_reg.trig);
    rd       = reg_rd_en;
    wr       = reg_wr_en;
    acc_addr = reg_addr_load ? reg_addr : st_reg.ptr;
    // Zero threshold would mean no room, so the limit falls back to full depth
    // Threshold compared at eight bits so a reduced depth cannot alias it
    if (st_reg.bctl[pts_pkg::BCTL_STOP_BIT] && (st_reg.wtm != 7'h00)
        && ({1'b0, st_reg.wtm} < 8'(FULL_CNT)))
      lim = CW'(st_reg.wtm);
    else
      lim = FULL_CNT;
    full      = (fifo_level >= lim);
    full_flag = (fifo_level == FULL_CNT);
    wtm_flag  = (st_reg.wtm != 7'h00) && (8'(fifo_level) >= {1'b0, st_reg.wtm});
    host_pop  = rd && (acc_addr == pts_pkg::A_BT1)
              && (bhv != pts_pkg::PTS_BHV_BYPASS) && fifo_out_valid;
    overwrite = sample_valid && (bhv == pts_pkg::PTS_BHV_STREAM)
              && full && !host_pop;
    fifo_in_valid = sample_valid && (bhv != pts_pkg::PTS_BHV_BYPASS)
                  && !((bhv == pts_pkg::PTS_BHV_STOP) && full);
    // Any write of the control byte restarts the buffer from empty
    flush   = (bhv == pts_pkg::PTS_BHV_BYPASS)
            || (wr && (acc_addr == pts_pkg::A_BCTL));
    ia_rise = interrupt_active && !st_reg.ia_prev;
  end

  // ==========================================================================
  // Read data selection
  always_comb
  begin
    rd_mux = pts_pkg::REG_RST;
    unique case (acc_addr)
      pts_pkg::A_THR_CFG:  rd_mux = st_reg.thr_cfg;
      pts_pkg::A_CTRL_TWO: rd_mux = st_reg.ctrl_two;
      pts_pkg::A_ROUTE:    rd_mux = st_reg.route;
      pts_pkg::A_BCTL:     rd_mux = st_reg.bctl;
      pts_pkg::A_WTM:      rd_mux = {1'b0, st_reg.wtm};
      pts_pkg::A_SRC:      rd_mux[pts_pkg::SRC_IA_BIT] = st_reg.ia_prev;
      pts_pkg::A_LEVEL:    rd_mux = 8'(fifo_level);
      pts_pkg::A_FLAGS:
      begin
        rd_mux[pts_pkg::FLAG_WTM_BIT]  = wtm_flag;
        rd_mux[pts_pkg::FLAG_OVR_BIT]  = st_reg.ovr;
        rd_mux[pts_pkg::FLAG_FULL_BIT] = full_flag;
      end
      pts_pkg::A_P0:       rd_mux = st_reg.press[7:0];
      pts_pkg::A_P1:       rd_mux = st_reg.press[15:8];
      pts_pkg::A_P2:       rd_mux = st_reg.press[23:16];
      pts_pkg::A_T0:       rd_mux = st_reg.temp[7:0];
      pts_pkg::A_T1:       rd_mux = st_reg.temp[15:8];
      // Bypass holds only the latest sample, so the window mirrors it
      pts_pkg::A_BP0:
        rd_mux = (bhv == pts_pkg::PTS_BHV_BYPASS) ? st_reg.press[7:0] : fifo_data[7:0];
      pts_pkg::A_BP1:
        rd_mux = (bhv == pts_pkg::PTS_BHV_BYPASS) ? st_reg.press[15:8] : fifo_data[15:8];
      pts_pkg::A_BP2:
        rd_mux = (bhv == pts_pkg::PTS_BHV_BYPASS) ? st_reg.press[23:16] : fifo_data[23:16];
      pts_pkg::A_BT0:
        rd_mux = (bhv == pts_pkg::PTS_BHV_BYPASS) ? st_reg.temp[7:0] : fifo_data[31:24];
      pts_pkg::A_BT1:
        rd_mux = (bhv == pts_pkg::PTS_BHV_BYPASS) ? st_reg.temp[15:8] : fifo_data[39:32];
      default:             rd_mux = pts_pkg::REG_RST;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_next         = st_reg;
    st_next.ia_prev = interrupt_active;
    st_next.rvalid  = rd;
    if (rd)
      st_next.rdata = rd_mux;
    if (rd || wr)
    begin
      if (st_reg.ctrl_two[pts_pkg::AUTOINC_BIT])
        st_next.ptr = advance(acc_addr);
      else
        st_next.ptr = acc_addr;
    end
    else if (reg_addr_load)
      st_next.ptr = reg_addr;
    if (wr)
    begin
      unique case (acc_addr)
        pts_pkg::A_THR_CFG:  st_next.thr_cfg  = reg_wdata;
        pts_pkg::A_CTRL_TWO: st_next.ctrl_two = reg_wdata;
        pts_pkg::A_ROUTE:    st_next.route    = reg_wdata;
        pts_pkg::A_BCTL:
        begin
          st_next.bctl = reg_wdata;
          st_next.trig = 1'b0;
        end
        pts_pkg::A_WTM:      st_next.wtm      = reg_wdata[6:0];
        default:             st_next.thr_cfg  = st_reg.thr_cfg;
      endcase
    end
    // Edge seen under the new code still arms it: the set beats the clear
    if (ia_rise && is_trig_code(st_next.bctl))
      st_next.trig = 1'b1;
    if (rd && (acc_addr == pts_pkg::A_T1))
      st_next.drdy = 1'b0;
    if (sample_valid)
    begin
      st_next.press = sample_press;
      st_next.temp  = sample_temp;
      st_next.drdy  = 1'b1;
    end
    if (flush || host_pop)
      st_next.ovr = 1'b0;
    if (overwrite)
      st_next.ovr = 1'b1;
    st_next.irq = (st_reg.route[pts_pkg::ROUTE_DRDY_BIT] && st_next.drdy)
                || (st_reg.route[pts_pkg::ROUTE_OVR_BIT] && st_next.ovr)
                || (st_reg.route[pts_pkg::ROUTE_WTM_BIT] && wtm_flag)
                || (st_reg.route[pts_pkg::ROUTE_FULL_BIT] && full_flag);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_reg          <= '0;
      st_reg.ctrl_two <= pts_pkg::CTRL_TWO_RST;
    end
    else
      st_reg <= st_next;
  end

  assign reg_rdata       = st_reg.rdata;
  assign reg_rdata_valid = st_reg.rvalid;
  assign irq_output_pin  = st_reg.irq;
  assign data_ready      = st_reg.drdy;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_ia_rise_armed;
    interrupt_active && !st_reg.ia_prev && !wr && is_trig_code(st_reg.bctl);
  endsequence

  sequence s_flags_read;
    rd && (acc_addr == pts_pkg::A_FLAGS);
  endsequence

  sequence s_ctrl_write;
    wr && (acc_addr == pts_pkg::A_BCTL);
  endsequence

  sequence s_stream_store;
    sample_valid && (bhv == pts_pkg::PTS_BHV_STREAM) && !full && !host_pop && !flush;
  endsequence

  AST_BYPASS_EMPTY: assert property (
    (bhv == pts_pkg::PTS_BHV_BYPASS) |=> (fifo_level == '0))
    else $error("buffer not empty in bypass");

  AST_WTM_ZERO: assert property (
    s_flags_read and (st_reg.wtm == 7'h00) |=> !reg_rdata[pts_pkg::FLAG_WTM_BIT])
    else $error("threshold flag set with zero threshold");

  AST_WTM_SET: assert property (
    s_flags_read and (st_reg.wtm != 7'h00) and (8'(fifo_level) >= {1'b0, st_reg.wtm})
    |=> reg_rdata[pts_pkg::FLAG_WTM_BIT] && reg_rdata_valid)
    else $error("threshold flag missing");

  AST_STOP_HOLD: assert property (
    sample_valid && (bhv == pts_pkg::PTS_BHV_STOP) && full && !host_pop && !flush
    |=> fifo_level == $past(fifo_level))
    else $error("stop behaviour stored past its limit");

  AST_OVERWRITE: assert property (
    overwrite && !flush |=> st_reg.ovr && (fifo_level == $past(fifo_level)))
    else $error("overwrite lost flag or count");

  AST_POP: assert property (
    host_pop && !fifo_in_valid && !flush |=> fifo_level == $past(fifo_level) - CW'(1))
    else $error("fifth byte read did not pop");

  AST_WRAP: assert property (
    (rd || wr) && (acc_addr == pts_pkg::A_BT1)
    && st_reg.ctrl_two[pts_pkg::AUTOINC_BIT] |=> st_reg.ptr == pts_pkg::A_BP0)
    else $error("read window did not wrap");

  AST_DRDY: assert property (
    sample_valid |=> data_ready ##1 (data_ready || $past(rd)))
    else $error("data ready not raised");

  AST_TRIG: assert property (
    s_ia_rise_armed |=> st_reg.trig)
    else $error("trigger edge not captured");

  AST_CTRL_FLUSH: assert property (
    s_ctrl_write |=> (fifo_level == '0))
    else $error("control write did not empty the buffer");

  AST_STREAM_STORE: assert property (
    s_stream_store |=> fifo_level == $past(fifo_level) + CW'(1))
    else $error("continuous behaviour lost a sample");

  AST_FIFO_ACCEPT: assert property (
    fifo_in_valid |-> fifo_in_ready)
    else $error("sample offered to a buffer that cannot take it");

  AST_IRQ_OVR: assert property (
    st_reg.ovr && st_reg.route[pts_pkg::ROUTE_OVR_BIT] && $stable(st_reg.route)
    |-> irq_output_pin)
    else $error("overwrite not routed to the interrupt pin");

  AST_ADDR_HOLD: assert property (
    (rd || wr) && !st_reg.ctrl_two[pts_pkg::AUTOINC_BIT] |=> st_reg.ptr == $past(acc_addr))
    else $error("pointer moved with auto-increment off");

  AST_LEVEL_MAX: assert property (
    fifo_level <= FULL_CNT)
    else $error("unread count above depth");

endmodule

`default_nettype wire

/* File: verification/pts_host_model.sv */
// Host-side model that drives the register port of the sample buffer
`timescale 1ns/1ps
`default_nettype none

module pts_host_model
(
  input  wire logic       sys_clk,
  output logic [6:0]      reg_addr,
  output logic            reg_addr_load,
  output logic            reg_wr_en,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rdata_valid
);
  // ==========================================================================
  // Byte accesses, driven on the falling edge
  logic [7:0] rbuf [0:63];

  initial
  begin
    reg_addr = 7'h00;
    reg_addr_load = 1'b0;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_addr_load = 1'b1;
    reg_wr_en = 1'b1;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_addr_load = 1'b0;
    reg_wr_en = 1'b0;
    // Released data must not keep showing the last byte
    reg_wdata = ~d;
  endtask

  task automatic set_mode(input logic [7:0] c);
    wr(pts_pkg::A_BCTL, 8'h00);
    wr(pts_pkg::A_BCTL, c);
  endtask

  // A byte without its valid pulse is stored unknown so that it never matches
  task automatic rd(input logic [6:0] a, input int n);
    for (int k = 0; k <= n; k++)
    begin
      @(negedge sys_clk);
      if (k > 0)
        rbuf[k-1] = (reg_rdata_valid === 1'b1) ? reg_rdata : 8'hxx;
      reg_rd_en = (k < n);
      reg_addr_load = (k == 0);
      reg_addr = a;
    end
  endtask
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking testbench of the sample buffer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        sys_clk, srst, sample_valid, interrupt_active;
  logic [23:0] sample_press;
  logic [15:0] sample_temp;
  logic [6:0]  reg_addr;
  logic        reg_addr_load, reg_wr_en, reg_rd_en, reg_rdata_valid;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        irq_output_pin, data_ready;
  int          miscompares = 0;
  int          n_compared = 0;

  // ==========================================================================
  // Clock, design and host
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  // Small depth keeps fill and overwrite cases short
  pts_buffer #(.DEPTH(8)) pts_buffer_inst (.sys_clk(sys_clk), .srst(srst),
    .sample_valid(sample_valid), .sample_press(sample_press), .sample_temp(sample_temp),
    .interrupt_active(interrupt_active), .reg_addr(reg_addr), .reg_addr_load(reg_addr_load),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .irq_output_pin(irq_output_pin), .data_ready(data_ready));

  pts_host_model pts_host_model_inst (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_addr_load(reg_addr_load), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid));

  // ==========================================================================
  // Helpers
  // Byte j of sample i in 78h..7Ch order; negative temperatures on purpose
  function automatic logic [7:0] eb(input int i, input int j);
    logic [39:0] e;
    e = {8'hf0 + i[7:0], 8'h40 + i[7:0], 8'h30 + i[7:0], 8'h20 + i[7:0], 8'h10 + i[7:0]};
    return e[8*j +: 8];
  endfunction

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: pin %b, wanted %b", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    pts_host_model_inst.rd(a, 1);
    chk8(pts_host_model_inst.rbuf[0], e);
  endtask

  task automatic push(input int i);
    @(negedge sys_clk);
    sample_valid = 1'b1;
    {sample_temp, sample_press} = {eb(i, 4), eb(i, 3), eb(i, 2), eb(i, 1), eb(i, 0)};
    @(negedge sys_clk);
    sample_valid = 1'b0;
  endtask

  task automatic pushn(input int a, input int n);
    for (int i = a; i < a + n; i++)
      push(i);
  endtask

  task automatic rdchk(input logic [6:0] a, input int n, input int first);
    pts_host_model_inst.rd(a, n);
    for (int k = 0; k < n; k++)
      chk8(pts_host_model_inst.rbuf[k], eb(first + k / 5, k % 5));
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rchk(pts_pkg::A_CTRL_TWO, pts_pkg::CTRL_TWO_RST);
    pts_host_model_inst.rd(pts_pkg::A_CTRL_TWO, 3);
    for (int k = 0; k < 3; k++)
      chk8(pts_host_model_inst.rbuf[k], k == 0 ? pts_pkg::CTRL_TWO_RST : 8'h00);
    // Without auto-increment the pointer must stay on one register
    pts_host_model_inst.wr(pts_pkg::A_THR_CFG, 8'h5a);
    pts_host_model_inst.wr(pts_pkg::A_CTRL_TWO, 8'h00);
    pts_host_model_inst.rd(pts_pkg::A_THR_CFG, 2);
    for (int k = 0; k < 2; k++)
      chk8(pts_host_model_inst.rbuf[k], 8'h5a);
    pts_host_model_inst.wr(pts_pkg::A_CTRL_TWO, pts_pkg::CTRL_TWO_RST);
    pts_host_model_inst.wr(pts_pkg::A_LEVEL, 8'hff);
    rchk(pts_pkg::A_LEVEL, 8'h00);
    rchk(7'h01, 8'h00);
  endtask

  task automatic t_bypass();
    pts_host_model_inst.wr(pts_pkg::A_ROUTE, 8'h04);
    for (int c = 0; c < 2; c++)
    begin
      pts_host_model_inst.set_mode(c == 0 ? 8'h00 : 8'h04);
      push(c + 1);
      chk1(data_ready, 1'b1);
      chk1(irq_output_pin, 1'b1);
      rchk(pts_pkg::A_LEVEL, 8'h00);
      rdchk(pts_pkg::A_P0, 5, c + 1);
      @(negedge sys_clk);
      chk1(data_ready, 1'b0);
      chk1(irq_output_pin, 1'b0);
      rdchk(pts_pkg::A_BP0, 5, c + 1);
    end
  endtask

  task automatic t_fifo();
    pts_host_model_inst.wr(pts_pkg::A_WTM, 8'h03);
    pts_host_model_inst.wr(pts_pkg::A_ROUTE, 8'h10);
    pts_host_model_inst.set_mode(8'h01);
    pushn(0, 9);
    rchk(pts_pkg::A_LEVEL, 8'h08);
    rchk(pts_pkg::A_FLAGS, 8'ha0);
    chk1(irq_output_pin, 1'b1);
    rdchk(pts_pkg::A_BP0, 40, 0);
    rchk(pts_pkg::A_LEVEL, 8'h00);
    repeat (3) @(negedge sys_clk);
    chk1(irq_output_pin, 1'b0);
  endtask

  task automatic t_stream();
    pts_host_model_inst.wr(pts_pkg::A_ROUTE, 8'h08);
    pts_host_model_inst.set_mode(8'h03);
    pushn(0, 10);
    chk1(irq_output_pin, 1'b1);
    rchk(pts_pkg::A_LEVEL, 8'h08);
    rchk(pts_pkg::A_FLAGS, 8'he0);
    rdchk(pts_pkg::A_BP0, 5, 2);
    rchk(pts_pkg::A_LEVEL, 8'h07);
    chk1(irq_output_pin, 1'b0);
    rdchk(pts_pkg::A_BP0, 35, 3);
    pushn(20, 2);
    rdchk(pts_pkg::A_BP0, 5, 20);
    pts_host_model_inst.wr(pts_pkg::A_BCTL, 8'h00);
    rchk(pts_pkg::A_LEVEL, 8'h00);
  endtask

  task automatic t_stop_wtm();
    pts_host_model_inst.set_mode(8'h09);
    pushn(0, 5);
    rchk(pts_pkg::A_LEVEL, 8'h03);
    pts_host_model_inst.wr(pts_pkg::A_WTM, 8'h00);
    rchk(pts_pkg::A_FLAGS, 8'h00);
  endtask

  // Trigger is pulsed before the samples, so the switch must be remembered
  task automatic t_trig(input logic [7:0] c, input logic [7:0] pre, input logic ovr,
                        input int first);
    pts_host_model_inst.set_mode(c);
    pushn(0, 3);
    rchk(pts_pkg::A_LEVEL, pre);
    @(negedge sys_clk);
    interrupt_active = 1'b1;
    @(negedge sys_clk);
    interrupt_active = 1'b0;
    pushn(3, 10);
    rchk(pts_pkg::A_LEVEL, 8'h08);
    rchk(pts_pkg::A_FLAGS, {1'b0, ovr, 6'h20});
    rchk(pts_pkg::A_BP0, eb(first, 0));
  endtask

  // ==========================================================================
  // Sequence and verdict
  task automatic test_done();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    srst = 1'b1;
    sample_valid = 1'b0;
    sample_press = 24'h000000;
    sample_temp = 16'h0000;
    interrupt_active = 1'b0;
    repeat (4) @(negedge sys_clk);
    srst = 1'b0;
    t_reset();
    t_bypass();
    t_fifo();
    t_stream();
    t_stop_wtm();
    t_trig(8'h05, 8'h00, 1'b0, 3);
    t_trig(8'h06, 8'h00, 1'b1, 5);
    t_trig(8'h07, 8'h03, 1'b0, 0);
    test_done();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    #400000;
    miscompares++;
    test_done();
  end
endmodule

`default_nettype wire
